/* rtl/mdu_pkg.sv */
// Package for the multiply/divide unit: register indices, status bits,
// write-order tracking states and calculation times.
// Assumes a single system clock shared by host core and unit.
package mdu_pkg;
   // ----------------------------------------
   // Register indices and status layout
   // ----------------------------------------
   localparam logic [2:0] MDU_IDX_BYTE0 = 3'h0;
   localparam logic [2:0] MDU_IDX_BYTE1 = 3'h1;
   localparam logic [2:0] MDU_IDX_BYTE2 = 3'h2;
   localparam logic [2:0] MDU_IDX_BYTE3 = 3'h3;
   localparam logic [2:0] MDU_IDX_BYTE4 = 3'h4;
   localparam logic [2:0] MDU_IDX_BYTE5 = 3'h5;
   localparam logic [2:0] MDU_IDX_STATUS = 3'h6;
   localparam int MDU_ERR_BIT = 7;
   localparam int MDU_OVF_BIT = 6;
   localparam logic [7:0] MDU_STATUS_RST = 8'h00;
   // ----------------------------------------
   // Calculation times in system clock periods
   // ----------------------------------------
   localparam int MDU_DIV32_CYC = 17;
   localparam int MDU_DIV16_CYC = 9;
   localparam int MDU_MUL_CYC = 11;
   // ----------------------------------------
   // Operations and write-order tracking
   // ----------------------------------------
   typedef enum logic [1:0] {
      MDU_OP_DIV32 = 2'h0,
      MDU_OP_DIV16 = 2'h1,
      MDU_OP_MUL = 2'h2
   } mdu_op_t;
   // Gray codes along the 32/16 divide path
   typedef enum logic [3:0] {
      MDU_SQ_IDLE = 4'h0,
      MDU_SQ_W0 = 4'h1,
      MDU_SQ_W01 = 4'h3,
      MDU_SQ_W012 = 4'h2,
      MDU_SQ_W0123 = 4'h6,
      MDU_SQ_W01234 = 4'h7,
      MDU_SQ_W014 = 4'h5,
      MDU_SQ_W04 = 4'h4,
      MDU_SQ_W041 = 4'hC
   } mdu_seq_t;
endpackage

/* rtl/mdu_reg_if.sv */
// Interface carrying the host core's register port to the unit.
// Assumes single-cycle read and write strobes on one clock.
`timescale 1ns/1ps
interface mdu_reg_if;
   logic wr;
   logic rd;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic busy;
   modport unit (input wr, input rd, input addr, input wdata,
      output rdata, output busy);
   modport core (output wr, output rd, output addr, output wdata,
      input rdata, input busy);
endinterface

/* rtl/mdu_unit.sv */
// Multiply/divide unit: six operand/result bytes and a status register.
// Assumes the core's strobes are synchronous to i_clk_sys.
//
// How it works
// - 16x16 multiply, 32/16 divide, unsigned.
// - Start only on write completing order.
// - Host writes low byte before high byte.
// - Gaps between operand writes are harmless.
// - Writes 0..5 select 32/16 divide.
// - Writes 0,1,4,5 select 16/16 divide.
// - Writes 0,4,1,5 select multiply.
// - Busy 17, 9 or 11 clocks.
// - Host leaves data registers alone while busy.
// - Data byte access while busy sets error bit 7.
// - Status read after completion clears error.
// - Completion rewrites overflow bit 6.
// - Status bits 5..0 read zero.
// - Host checks status before taking results.
// - 32/16 results: quotient 0..3, remainder 4..5.
// - 16/16 results: quotient 0,1, remainder 4,5.
// - Product bytes 0..3 in registers 0..3.
// - Gaps between result reads are harmless.
// - Host does not sleep while busy.
`timescale 1ns/1ps
module mdu_unit
   import mdu_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Register port
   mdu_reg_if.unit bus
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] data_r [0:5];
   mdu_seq_t seq_r, seq_nxt;
   mdu_op_t op_r;
   logic [4:0] cnt_r;
   logic busy_r;
   logic err_r;
   logic ovf_r;
   logic start;
   mdu_op_t start_op;
   logic data_acc;
   logic done;
   logic [31:0] dvd;
   logic [15:0] dvs;
   logic [31:0] quo;
   logic [15:0] rem;
   logic [31:0] prod;

   assign data_acc = (bus.wr | bus.rd) && bus.addr <= MDU_IDX_BYTE5;
   assign done = busy_r && cnt_r == 5'h01;
   assign bus.busy = busy_r;

   // ----------------------------------------
   // Write-order tracking
   // ----------------------------------------
   always_comb begin
      seq_nxt = seq_r;
      start = 1'b0;
      start_op = MDU_OP_DIV32;
      if (bus.wr && !busy_r && bus.addr <= MDU_IDX_BYTE5) begin
         seq_nxt = MDU_SQ_IDLE;
         unique case (bus.addr)
            MDU_IDX_BYTE0: seq_nxt = MDU_SQ_W0;
            MDU_IDX_BYTE1: begin
               if (seq_r == MDU_SQ_W0) seq_nxt = MDU_SQ_W01;
               else if (seq_r == MDU_SQ_W04) seq_nxt = MDU_SQ_W041;
            end
            MDU_IDX_BYTE2: begin
               if (seq_r == MDU_SQ_W01) seq_nxt = MDU_SQ_W012;
            end
            MDU_IDX_BYTE3: begin
               if (seq_r == MDU_SQ_W012) seq_nxt = MDU_SQ_W0123;
            end
            MDU_IDX_BYTE4: begin
               if (seq_r == MDU_SQ_W0123) seq_nxt = MDU_SQ_W01234;
               else if (seq_r == MDU_SQ_W01) seq_nxt = MDU_SQ_W014;
               else if (seq_r == MDU_SQ_W0) seq_nxt = MDU_SQ_W04;
            end
            default: begin
               // Write order before the last operand byte decides the operation
               if (seq_r == MDU_SQ_W01234) begin
                  start = 1'b1;
                  start_op = MDU_OP_DIV32;
               end else if (seq_r == MDU_SQ_W014) begin
                  start = 1'b1;
                  start_op = MDU_OP_DIV16;
               end else if (seq_r == MDU_SQ_W041) begin
                  start = 1'b1;
                  start_op = MDU_OP_MUL;
               end
               seq_nxt = MDU_SQ_IDLE;
            end
         endcase
      end
   end

   // Other accesses leave the tracking untouched
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) seq_r <= MDU_SQ_IDLE;
      else seq_r <= seq_nxt;
   end

   // ----------------------------------------
   // Calculation timer
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         busy_r <= 1'b0;
         cnt_r <= 5'h00;
         op_r <= MDU_OP_DIV32;
      end else if (start) begin
         busy_r <= 1'b1;
         op_r <= start_op;
         unique case (start_op)
            MDU_OP_DIV32: cnt_r <= 5'(MDU_DIV32_CYC);
            MDU_OP_DIV16: cnt_r <= 5'(MDU_DIV16_CYC);
            default: cnt_r <= 5'(MDU_MUL_CYC);
         endcase
      end else if (busy_r) begin
         cnt_r <= cnt_r - 5'h01;
         if (done) busy_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Arithmetic, settled on the operand bytes
   // ----------------------------------------
   always_comb begin
      dvs = {data_r[5], data_r[4]};
      if (op_r == MDU_OP_DIV32)
         dvd = {data_r[3], data_r[2], data_r[1], data_r[0]};
      else
         dvd = {16'h0000, data_r[1], data_r[0]};
      if (dvs == 16'h0000) begin
         quo = 32'hFFFFFFFF;
         rem = dvd[15:0];
      end else begin
         quo = dvd / {16'h0000, dvs};
         rem = 16'(dvd % {16'h0000, dvs});
      end
      prod = {data_r[1], data_r[0]} * {data_r[5], data_r[4]};
   end

   // ----------------------------------------
   // Operand/result bytes, no reset
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (done) begin
         if (op_r == MDU_OP_MUL) begin
            {data_r[3], data_r[2], data_r[1], data_r[0]} <= prod;
         end else begin
            {data_r[3], data_r[2], data_r[1], data_r[0]} <= quo;
            {data_r[5], data_r[4]} <= rem;
         end
      end else if (bus.wr && !busy_r && bus.addr <= MDU_IDX_BYTE5) begin
         data_r[bus.addr] <= bus.wdata;
      end
   end

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         err_r <= MDU_STATUS_RST[MDU_ERR_BIT];
         ovf_r <= MDU_STATUS_RST[MDU_OVF_BIT];
      end else begin
         if (busy_r && data_acc) err_r <= 1'b1;
         else if (bus.rd && bus.addr == MDU_IDX_STATUS && !busy_r)
            err_r <= 1'b0;
         if (done) begin
            if (op_r == MDU_OP_MUL) ovf_r <= prod[31:16] != 16'h0000;
            else ovf_r <= dvs == 16'h0000;
         end
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb begin
      bus.rdata = 8'h00;
      if (bus.addr <= MDU_IDX_BYTE5) bus.rdata = data_r[bus.addr];
      else if (bus.addr == MDU_IDX_STATUS)
         bus.rdata = {err_r, ovf_r, 6'h00};
   end
endmodule

/* rtl/mdu_core_port.sv */
// Host-side end: turns operation requests into ordered register writes,
// waits, checks status and reads the results back in order.
// Assumes the unit answers reads combinationally in the same cycle.
`timescale 1ns/1ps
module mdu_core_port
   import mdu_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // User request
   input wire logic i_req,
   input wire logic [1:0] i_op,
   input wire logic [31:0] i_a,
   input wire logic [15:0] i_b,
   // User answer
   output logic o_ready,
   output logic o_done,
   output logic o_ok,
   output logic o_ovf,
   output logic [31:0] o_res,
   output logic [15:0] o_rem,
   // Register port
   mdu_reg_if.core bus
);
   typedef enum logic [2:0] {
      MDU_HS_IDLE = 3'h0, MDU_HS_WR = 3'h1, MDU_HS_WAIT = 3'h3,
      MDU_HS_STAT = 3'h2, MDU_HS_RD = 3'h6, MDU_HS_FIN = 3'h7
   } mdu_hst_t;
   mdu_hst_t st_r;
   mdu_op_t op_r;
   logic [31:0] a_r;
   logic [15:0] b_r;
   logic [2:0] step_r;
   logic [2:0] last;
   logic [2:0] idx;

   // Register index of each write or read step
   function automatic logic [2:0] step_idx(input mdu_op_t op,
      input logic [2:0] s);
      step_idx = s;
      if (op == MDU_OP_MUL) begin
         case (s)
            3'h1: step_idx = MDU_IDX_BYTE4;
            3'h2: step_idx = MDU_IDX_BYTE1;
            3'h3: step_idx = MDU_IDX_BYTE5;
            default: step_idx = s;
         endcase
      end else if (op == MDU_OP_DIV16 && s >= 3'h2) begin
         step_idx = s + 3'h2;
      end
   endfunction

   assign last = op_r == MDU_OP_DIV32 ? 3'h5 : 3'h3;
   // Product reads run 0..3 in plain order
   assign idx = (st_r == MDU_HS_RD && op_r == MDU_OP_MUL) ? step_r :
      step_idx(op_r, step_r);
   assign o_ready = st_r == MDU_HS_IDLE;
   assign bus.wr = st_r == MDU_HS_WR;
   assign bus.rd = st_r == MDU_HS_STAT || st_r == MDU_HS_RD;
   assign bus.addr = st_r == MDU_HS_STAT ? MDU_IDX_STATUS : idx;
   assign bus.wdata = idx == MDU_IDX_BYTE4 ? b_r[7:0] :
      idx == MDU_IDX_BYTE5 ? b_r[15:8] : a_r[8*idx +: 8];

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_r <= MDU_HS_IDLE;
         step_r <= 3'h0;
         op_r <= MDU_OP_DIV32;
         a_r <= 32'h0;
         b_r <= 16'h0;
         o_done <= 1'b0;
         o_ok <= 1'b0;
         o_ovf <= 1'b0;
         o_res <= 32'h0;
         o_rem <= 16'h0;
      end else begin
         o_done <= 1'b0;
         unique case (st_r)
            MDU_HS_IDLE: if (i_req && i_op != 2'h3) begin
               op_r <= mdu_op_t'(i_op);
               a_r <= i_a;
               b_r <= i_b;
               step_r <= 3'h0;
               st_r <= MDU_HS_WR;
            end
            MDU_HS_WR: begin
               step_r <= step_r + 3'h1;
               if (step_r == last) st_r <= MDU_HS_WAIT;
            end
            MDU_HS_WAIT: begin
               step_r <= 3'h0;
               if (!bus.busy) st_r <= MDU_HS_STAT;
            end
            MDU_HS_STAT: begin
               o_ok <= !bus.rdata[MDU_OVF_BIT] && !bus.rdata[MDU_ERR_BIT];
               o_ovf <= bus.rdata[MDU_OVF_BIT];
               o_res <= 32'h0;
               o_rem <= 16'h0;
               // Results taken only on a clean finish
               if (bus.rdata[MDU_OVF_BIT] || bus.rdata[MDU_ERR_BIT])
                  st_r <= MDU_HS_FIN;
               else st_r <= MDU_HS_RD;
            end
            MDU_HS_RD: begin
               if (idx == MDU_IDX_BYTE4) o_rem[7:0] <= bus.rdata;
               else if (idx == MDU_IDX_BYTE5) o_rem[15:8] <= bus.rdata;
               else o_res[8*idx +: 8] <= bus.rdata;
               step_r <= step_r + 3'h1;
               if (step_r == last) st_r <= MDU_HS_FIN;
            end
            MDU_HS_FIN: begin
               o_done <= 1'b1;
               st_r <= MDU_HS_IDLE;
            end
            default: st_r <= MDU_HS_IDLE;
         endcase
      end
   end
endmodule

/* tb/mdc_port_props.sv */
// Checker for the register port joining the core end to the unit.
// Assumes it stands beside the interface instance in the bench.
`timescale 1ns/1ps
module mdc_port_props
   import mdu_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Register port
   input wire logic wr,
   input wire logic rd,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic busy
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   logic err_r;
   logic [2:0] h1_r;
   logic [2:0] h2_r;
   int cnt_r;
   int len_r;
   wire acc_busy = busy && (wr || rd) && addr <= 3'h5;
   wire stat_rd = rd && addr == MDU_IDX_STATUS;
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) err_r <= 1'b0;
      else if (acc_busy) err_r <= 1'b1;
      else if (stat_rd && !busy) err_r <= 1'b0;
   end
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         h1_r <= 3'h0;
         h2_r <= 3'h0;
         len_r <= 0;
      end else if (wr && !busy) begin
         h1_r <= addr;
         h2_r <= h1_r;
         len_r <= h1_r == 3'h1 ? MDU_MUL_CYC :
            (h2_r == 3'h3 ? MDU_DIV32_CYC : MDU_DIV16_CYC);
      end
   end
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) cnt_r <= 0;
      else if (busy) cnt_r <= cnt_r + 1;
      else cnt_r <= 0;
   end
   sequence s_start;
      !busy ##1 busy;
   endsequence
   sequence s_finish;
      busy ##1 !busy;
   endsequence
   chk_status_pad_zero: assert property (stat_rd |-> rdata[5:0] == 6'h00)
      else $error("status padding bits not zero");
   chk_error_flag_bit: assert property (stat_rd |-> rdata[7] == err_r)
      else $error("error flag wrong on status read");
   chk_start_on_five: assert property (s_start |-> $past(wr) && $past(addr) == 3'h5)
      else $error("calculation started without write to byte five");
   chk_no_stray_start: assert property (!busy && !(wr && addr == 3'h5) |=> !busy)
      else $error("busy rose without a start write");
   chk_busy_run_length: assert property (s_finish |-> cnt_r == len_r)
      else $error("calculation time does not match operation");
   chk_busy_min_run: assert property (s_start |-> busy [*8])
      else $error("busy dropped too early");
   chk_idle_after_reset: assert property ($fell(i_sys_rst) |-> !busy)
      else $error("unit not idle after reset");
   chk_core_quiet_busy: assert property (busy |-> !((wr || rd) && addr <= 3'h5))
      else $error("core touched data bytes while busy");
endmodule

/* tb/mul_div_coprocessor_tb.sv */
// Bench: core end and unit joined, plus a second unit misused directly.
// Assumes package, interface and both design ends are compiled first.
`timescale 1ns/1ps
module mul_div_coprocessor_tb;
   import mdu_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_req = 1'b0;
   logic [1:0] i_op = 2'h0;
   logic [31:0] i_a = 32'h0;
   logic [15:0] i_b = 16'h0;
   logic o_ready, o_done, o_ok, o_ovf;
   logic [31:0] o_res, ra, p;
   logic [15:0] o_rem, rb;
   logic [51:0] n;
   logic [51:0] note_q[$];
   logic [7:0] byte_q[$];
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   mdu_reg_if link_a();
   mdu_reg_if link_b();
   mdu_unit mdu_unit_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .bus(link_a));
   mdu_unit mdu_unit_b_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .bus(link_b));
   mdu_core_port mdu_core_port_i (.i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst), .i_req(i_req), .i_op(i_op), .i_a(i_a),
      .i_b(i_b), .o_ready(o_ready), .o_done(o_done), .o_ok(o_ok),
      .o_ovf(o_ovf), .o_res(o_res), .o_rem(o_rem), .bus(link_a));
   mdc_port_props chk_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .wr(link_a.wr), .rd(link_a.rd), .addr(link_a.addr),
      .wdata(link_a.wdata), .rdata(link_a.rdata), .busy(link_a.busy));
   always #25 i_clk_sys = ~i_clk_sys;
   task automatic close_out();
      $display("Checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic run_op(input logic [1:0] op, input logic [31:0] a,
      input logic [15:0] b);
      logic [31:0] x, res;
      logic [15:0] rem;
      logic ovf;
      x = (op == 2'h0) ? a : {16'h0, a[15:0]};
      ovf = (b == 16'h0);
      res = 32'h0;
      rem = 16'h0;
      if (op == 2'h2) begin
         res = {16'h0, a[15:0]} * {16'h0, b};
         ovf = res > 32'hFFFF;
      end else if (!ovf) begin
         res = x / {16'h0, b};
         rem = 16'(x % {16'h0, b});
      end
      note_q.push_back({op, !ovf, ovf, rem, res});
      while (o_ready !== 1'b1) @(posedge i_clk_sys);
      i_req <= 1'b1;
      i_op <= op;
      i_a <= a;
      i_b <= b;
      @(posedge i_clk_sys);
      i_req <= 1'b0;
      do @(posedge i_clk_sys); while (o_done !== 1'b1);
   endtask
   task automatic put(input logic [2:0] idx, input logic [7:0] d);
      link_b.wr <= 1'b1;
      link_b.addr <= idx;
      link_b.wdata <= d;
      @(posedge i_clk_sys);
      link_b.wr <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   task automatic get(input logic [2:0] idx, input logic [7:0] e);
      byte_q.push_back(e);
      link_b.rd <= 1'b1;
      link_b.addr <= idx;
      @(posedge i_clk_sys);
      link_b.rd <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   always @(posedge i_clk_sys) begin
      if (o_done === 1'b1) begin
         n = note_q.pop_front();
         check("ok", {31'h0, n[49]}, {31'h0, o_ok});
         check("ovf", {31'h0, n[48]}, {31'h0, o_ovf});
         if (n[49] && n[51:50] == 2'h1) begin
            check("res", n[31:0], {16'h0, o_res[15:0]});
         end else if (n[49]) begin
            check("res", n[31:0], o_res);
         end
         if (n[49] && n[51:50] != 2'h2) begin
            check("rem", {16'h0, n[47:32]}, {16'h0, o_rem});
         end
      end
      if (link_b.rd === 1'b1) begin
         check("rdata", {24'h0, byte_q.pop_front()},
            {24'h0, link_b.rdata});
      end
   end
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         error_cnt++;
         close_out();
      end
   end
   initial begin
      link_b.wr = 1'b0;
      link_b.rd = 1'b0;
      link_b.addr = 3'h0;
      link_b.wdata = 8'h00;
      void'($urandom(47));
      repeat (16) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      @(posedge i_clk_sys);
      for (int k = 0; k < 30; k++) begin
         ra = $urandom;
         rb = 16'($urandom);
         if (k % 3 == 2) begin
            ra &= 32'hFF;
            rb &= 16'hFF;
         end
         run_op(2'(k % 3), ra, rb);
      end
      run_op(2'h0, 32'hFFFFFFFF, 16'h0001);
      run_op(2'h1, 32'h1234, 16'h0000);
      run_op(2'h2, 32'hFFFF, 16'hFFFF);
      get(MDU_IDX_STATUS, 8'h00);
      put(3'h0, 8'h11);
      put(3'h1, 8'h22);
      put(3'h5, 8'h33);
      check("busy", 32'h0, {31'h0, link_b.busy});
      p = 32'h1234 * 32'h5678;
      put(3'h0, 8'h34);
      put(3'h4, 8'h78);
      put(3'h1, 8'h12);
      put(3'h5, 8'h56);
      check("busy", 32'h1, {31'h0, link_b.busy});
      put(3'h0, 8'hAA);
      repeat (12) @(posedge i_clk_sys);
      get(MDU_IDX_STATUS, 8'hC0);
      get(MDU_IDX_STATUS, 8'h40);
      for (int k = 0; k < 4; k++) begin
         get(3'(k), p[8*k +: 8]);
      end
      @(posedge i_clk_sys);
      close_out();
   end
endmodule
